// ==== logic/hash_select.sv ====
// hash table bit pick and multicast accept decision
// assumes the 6-bit hash index is computed upstream from the destination address
module hash_select (
	input  wire logic [31:0] table_upper,
	input  wire logic [31:0] table_lower,
	input  wire logic [5:0]  hash_index,
	input  wire logic        pass_all,
	output logic             accept
);
	logic picked;
	always_comb begin
		// top index bit picks the register, low five bits the bit in it
		picked = hash_index[5] ? table_upper[hash_index[4:0]] : table_lower[hash_index[4:0]]; // [RQ7] [RQ8] [RQ11]
		accept = pass_all | picked; // [RQ9] [RQ10]
	end
endmodule : hash_select

// ==== logic/mac_filt_cfg.svh ====
// register offsets, reset values and timing constants for the mac address/hash/phy management bank
// assumes avalon-mm word addressing with index = printed offset
`ifndef MAC_FILT_CFG_SVH
`define MAC_FILT_CFG_SVH
`define OFS_ADDR_HIGH      4'h2
`define OFS_ADDR_LOW       4'h3
`define OFS_TABLE_UPPER    4'h4
`define OFS_TABLE_LOWER    4'h5
`define OFS_MGMT_ACCESS    4'h6
`define OFS_MGMT_DATA      4'h7
`define OFS_FILTER_CTRL    4'h9
`define RST_ADDR_HIGH      32'h00000FFF
`define RST_ADDR_LOW       32'h0FFFFFFF
`define RST_ZERO           32'h00000000
`define ACC_BUSY_BIT       0
`define ACC_WRITE_BIT      1
`define ACC_IDX_LSB        6
`define ACC_PHYAD_LSB      11
`define CTRL_PASS_ALL_BIT  0
`define EE_FIRST_LOC       8'h01
`define EE_LAST_LOC        8'h06
`define MDC_HALF_NS        200
`define CLK_PERIOD_NS      10
`define MDC_HALF_CYC       (`MDC_HALF_NS / `CLK_PERIOD_NS)
`endif

// ==== logic/mac_filt_pkg.sv ====
// types used by the register bank for its state machines
// assumes nothing beyond a systemverilog compiler
package mac_filt_pkg;
	typedef enum logic [1:0] {mg_idle, mg_shift, mg_done} mgmt_state_t;
	typedef enum logic [1:0] {ee_start, ee_wait, ee_finish} ee_state_t;
endpackage : mac_filt_pkg

// ==== logic/mac_filt_regs.sv ====
// mac station address, multicast hash table and phy management register bank
// assumes avalon-mm master on clock, serial eeprom byte port and internal phy mdio
//
// What this block does
// [RQ1] high address register holds bits 47..32
// [RQ2] power-on eeprom load only if programmed
// [RQ3] high bytes from eeprom locations 5, 6
// [RQ4] low register from eeprom locations 1..4
// [RQ5] low byte zero goes first on wire
// [RQ6] address undefined until load; then host writable
// [RQ7] hash msb picks register, rest bit
// [RQ8] index 0 low bit0, 63 high bit31
// [RQ9] accept multicast when selected bit set
// [RQ10] pass-all accepts every multicast frame
// [RQ11] upper table bits 63..32, lower 31..0
// [RQ12] software writes phy address 00001b
// [RQ13] register index selects phy register
// [RQ14] write bit chooses phy write or read
// [RQ15] busy set by software, cleared when done
// [RQ16] software waits busy low before writing
// [RQ17] software holds data during phy write
// [RQ18] read data valid only after busy clears
// [RQ19] data register carries 16-bit phy value
// [RQ20] access runs as clause 22 frame
// [RQ21] reserved bits read zero, ignore writes
//
// The Avalon-MM register port was left to the implementer.
`include "mac_filt_cfg.svh"
module mac_filt_regs #(
	parameter int mdc_half = `MDC_HALF_CYC
) (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	output logic             avs_response_err,
	input  wire logic        ee_present,
	input  wire logic        ee_ack,
	input  wire logic [7:0]  ee_data,
	output logic             ee_req,
	output logic [7:0]       ee_loc,
	output logic             init_done,
	input  wire logic [5:0]  hash_index,
	output logic             multicast_accept,
	output logic [47:0]      station_address,
	output logic             mdc,
	output logic             mdio_out,
	output logic             mdio_oe_n,
	input  wire logic        mdio_in
);
	initial if (mdc_half < 1) $error("mdc_half must be at least one");

	// reserved-bit masks
	localparam logic [31:0] mask_high = 32'h0000FFFF;
	localparam logic [31:0] mask_acc  = 32'h0000FFC3;
	localparam logic [31:0] mask_data = 32'h0000FFFF;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be,
		input logic [31:0] mask);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r & mask; // [RQ21]
	endfunction : merge

	logic [31:0] addr_high_ff, nxt_addr_high;
	logic [31:0] addr_low_ff, nxt_addr_low;
	logic [31:0] tab_up_ff, nxt_tab_up;
	logic [31:0] tab_lo_ff, nxt_tab_lo;
	logic [31:0] acc_ff, nxt_acc;
	logic [31:0] data_ff, nxt_data;
	logic        pass_all_ff, nxt_pass_all;
	logic [31:0] rdata_ff, nxt_rdata;
	logic        wait_ff, nxt_wait;
	logic        err_ff, nxt_err;
	logic        ack_pulse;

	// eeprom load state
	mac_filt_pkg::ee_state_t ee_st_ff, nxt_ee_st;
	logic [7:0]  ee_loc_ff, nxt_ee_loc;
	logic        ee_req_ff, nxt_ee_req;
	logic        done_ff, nxt_done;

	// management frame state
	mac_filt_pkg::mgmt_state_t mg_st_ff, nxt_mg_st;
	logic [6:0]  bit_ff, nxt_bit;
	logic [63:0] shreg_ff, nxt_shreg;
	logic [15:0] rd_ff, nxt_rd;
	logic        mdc_ff, nxt_mdc;
	logic        mdo_ff, nxt_mdo;
	logic        oe_n_ff, nxt_oe_n;
	logic        is_wr_ff, nxt_is_wr;
	logic        tick;
	logic        acc_match;

	mdc_divider #(.half_cycles(mdc_half)) u_div (
		.clock(clock),
		.rst_n(rst_n),
		.run  (mg_st_ff == mac_filt_pkg::mg_shift),
		.tick (tick)
	);

	logic accept_c;
	hash_select u_hash (
		.table_upper(tab_up_ff),
		.table_lower(tab_lo_ff),
		.hash_index (hash_index),
		.pass_all   (pass_all_ff),
		.accept     (accept_c)
	);
	logic accept_ff;

	// avalon slave: one wait cycle, answer on the second
	always_comb begin
		nxt_wait  = 1'b1;
		ack_pulse = 1'b0;
		if ((avs_read | avs_write) & wait_ff) begin
			nxt_wait = 1'b0;
		end
		if ((avs_read | avs_write) & !wait_ff) begin
			ack_pulse = 1'b1;
		end
		nxt_rdata = rdata_ff;
		nxt_err   = 1'b0;
		if ((avs_read | avs_write) & wait_ff) begin
			nxt_rdata = 32'h00000000;
			case (avs_address)
				`OFS_ADDR_HIGH:   nxt_rdata = addr_high_ff; // [RQ1]
				`OFS_ADDR_LOW:    nxt_rdata = addr_low_ff;
				`OFS_TABLE_UPPER: nxt_rdata = tab_up_ff;
				`OFS_TABLE_LOWER: nxt_rdata = tab_lo_ff;
				`OFS_MGMT_ACCESS: nxt_rdata = acc_ff;
				`OFS_MGMT_DATA:   nxt_rdata = data_ff; // [RQ18]
				`OFS_FILTER_CTRL: nxt_rdata = {31'h00000000, pass_all_ff};
				default:          nxt_err   = 1'b1;
			endcase
		end
	end

	assign acc_match = avs_write & !wait_ff;

	// register file
	always_comb begin
		nxt_addr_high = addr_high_ff;
		nxt_addr_low  = addr_low_ff;
		nxt_tab_up    = tab_up_ff;
		nxt_tab_lo    = tab_lo_ff;
		nxt_acc       = acc_ff;
		nxt_data      = data_ff;
		nxt_pass_all  = pass_all_ff;
		if (acc_match) begin
			case (avs_address)
				`OFS_ADDR_HIGH:   nxt_addr_high = merge(addr_high_ff, avs_writedata, avs_byteenable, mask_high); // [RQ6]
				`OFS_ADDR_LOW:    nxt_addr_low  = merge(addr_low_ff, avs_writedata, avs_byteenable, 32'hFFFFFFFF);
				`OFS_TABLE_UPPER: nxt_tab_up    = merge(tab_up_ff, avs_writedata, avs_byteenable, 32'hFFFFFFFF);
				`OFS_TABLE_LOWER: nxt_tab_lo    = merge(tab_lo_ff, avs_writedata, avs_byteenable, 32'hFFFFFFFF);
				`OFS_MGMT_ACCESS: begin
					if (!acc_ff[`ACC_BUSY_BIT]) begin
						nxt_acc = merge(acc_ff, avs_writedata, avs_byteenable, mask_acc); // [RQ15] [RQ16]
					end
				end
				`OFS_MGMT_DATA: begin
					if (!acc_ff[`ACC_BUSY_BIT]) begin
						nxt_data = merge(data_ff, avs_writedata, avs_byteenable, mask_data); // [RQ17] [RQ19]
					end
				end
				`OFS_FILTER_CTRL: begin
					if (avs_byteenable[0]) begin
						nxt_pass_all = avs_writedata[`CTRL_PASS_ALL_BIT];
					end
				end
				default: begin
				end
			endcase
		end
		// eeprom bytes land in wire order, location 1 at low byte 0
		if (ee_req_ff & ee_ack) begin
			case (ee_loc_ff)
				8'h01: nxt_addr_low[7:0]   = ee_data; // [RQ4] [RQ5]
				8'h02: nxt_addr_low[15:8]  = ee_data;
				8'h03: nxt_addr_low[23:16] = ee_data;
				8'h04: nxt_addr_low[31:24] = ee_data;
				8'h05: nxt_addr_high[7:0]  = ee_data; // [RQ3]
				8'h06: nxt_addr_high[15:8] = ee_data;
				default: begin
				end
			endcase
		end
		if (mg_st_ff == mac_filt_pkg::mg_done) begin
			nxt_acc[`ACC_BUSY_BIT] = 1'b0; // [RQ15]
			if (!is_wr_ff) begin
				nxt_data = {16'h0000, rd_ff}; // [RQ14] [RQ18]
			end
		end
	end

	// power-on eeprom load
	always_comb begin
		nxt_ee_st  = ee_st_ff;
		nxt_ee_loc = ee_loc_ff;
		nxt_ee_req = ee_req_ff;
		nxt_done   = done_ff;
		case (ee_st_ff)
			mac_filt_pkg::ee_start: begin
				if (ee_present) begin
					nxt_ee_st  = mac_filt_pkg::ee_wait; // [RQ2]
					nxt_ee_loc = `EE_FIRST_LOC;
					nxt_ee_req = 1'b1;
				end else begin
					nxt_ee_st = mac_filt_pkg::ee_finish;
					nxt_done  = 1'b1;
				end
			end
			mac_filt_pkg::ee_wait: begin
				if (ee_ack) begin
					if (ee_loc_ff == `EE_LAST_LOC) begin
						nxt_ee_req = 1'b0;
						nxt_ee_st  = mac_filt_pkg::ee_finish;
						nxt_done   = 1'b1;
					end else begin
						nxt_ee_loc = ee_loc_ff + 8'h01;
					end
				end
			end
			mac_filt_pkg::ee_finish: begin
			end
			default: nxt_ee_st = mac_filt_pkg::ee_finish;
		endcase
	end

	// clause 22 frame: 32 preamble, st 01, op, phyad, regad, ta, data
	always_comb begin
		nxt_mg_st = mg_st_ff;
		nxt_bit   = bit_ff;
		nxt_shreg = shreg_ff;
		nxt_rd    = rd_ff;
		nxt_mdc   = mdc_ff;
		nxt_mdo   = mdo_ff;
		nxt_oe_n  = oe_n_ff;
		nxt_is_wr = is_wr_ff;
		case (mg_st_ff)
			mac_filt_pkg::mg_idle: begin
				nxt_mdc  = 1'b0;
				nxt_oe_n = 1'b1;
				if (acc_ff[`ACC_BUSY_BIT]) begin
					nxt_is_wr = acc_ff[`ACC_WRITE_BIT]; // [RQ14]
					nxt_shreg = {32'hFFFFFFFF, 2'b01, acc_ff[`ACC_WRITE_BIT] ? 2'b01 : 2'b10,
						acc_ff[`ACC_PHYAD_LSB +: 5], acc_ff[`ACC_IDX_LSB +: 5], 2'b10, data_ff[15:0]}; // [RQ13] [RQ20]
					nxt_bit   = 7'h00;
					nxt_mg_st = mac_filt_pkg::mg_shift;
				end
			end
			mac_filt_pkg::mg_shift: begin
				if (tick) begin
					nxt_mdc = !mdc_ff;
					if (mdc_ff) begin
						// falling edge: drive next bit, release from turnaround on reads
						// the last high phase runs its full length before the frame ends
						if (bit_ff == 7'd65) begin
							nxt_mg_st = mac_filt_pkg::mg_done;
						end else begin
							nxt_mdo   = shreg_ff[63];
							nxt_oe_n  = !is_wr_ff & (bit_ff >= 7'd47); // [RQ20]
							nxt_shreg = {shreg_ff[62:0], 1'b0};
						end
					end else begin
						if (bit_ff >= 7'd48) begin
							nxt_rd = {rd_ff[14:0], mdio_in};
						end
						nxt_bit = bit_ff + 7'h01;
					end
				end
			end
			mac_filt_pkg::mg_done: begin
				nxt_mdc   = 1'b0;
				nxt_oe_n  = 1'b1;
				nxt_mg_st = mac_filt_pkg::mg_idle;
			end
			default: nxt_mg_st = mac_filt_pkg::mg_idle;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			addr_high_ff <= `RST_ADDR_HIGH;
			addr_low_ff  <= `RST_ADDR_LOW;
			tab_up_ff    <= `RST_ZERO;
			tab_lo_ff    <= `RST_ZERO;
			acc_ff       <= `RST_ZERO;
			data_ff      <= `RST_ZERO;
			pass_all_ff  <= 1'b0;
			rdata_ff     <= `RST_ZERO;
			wait_ff      <= 1'b1;
			err_ff       <= 1'b0;
			ee_st_ff     <= mac_filt_pkg::ee_start;
			ee_loc_ff    <= 8'h00;
			ee_req_ff    <= 1'b0;
			done_ff      <= 1'b0;
			mg_st_ff     <= mac_filt_pkg::mg_idle;
			bit_ff       <= 7'h00;
			shreg_ff     <= 64'h0;
			rd_ff        <= 16'h0000;
			mdc_ff       <= 1'b0;
			mdo_ff       <= 1'b1;
			oe_n_ff      <= 1'b1;
			is_wr_ff     <= 1'b0;
			accept_ff    <= 1'b0;
		end else begin
			addr_high_ff <= nxt_addr_high;
			addr_low_ff  <= nxt_addr_low;
			tab_up_ff    <= nxt_tab_up;
			tab_lo_ff    <= nxt_tab_lo;
			acc_ff       <= nxt_acc;
			data_ff      <= nxt_data;
			pass_all_ff  <= nxt_pass_all;
			rdata_ff     <= nxt_rdata;
			wait_ff      <= ack_pulse ? 1'b1 : nxt_wait;
			err_ff       <= nxt_err;
			ee_st_ff     <= nxt_ee_st;
			ee_loc_ff    <= nxt_ee_loc;
			ee_req_ff    <= nxt_ee_req;
			done_ff      <= nxt_done;
			mg_st_ff     <= nxt_mg_st;
			bit_ff       <= nxt_bit;
			shreg_ff     <= nxt_shreg;
			rd_ff        <= nxt_rd;
			mdc_ff       <= nxt_mdc;
			mdo_ff       <= nxt_mdo;
			oe_n_ff      <= nxt_oe_n;
			is_wr_ff     <= nxt_is_wr;
			accept_ff    <= accept_c;
		end
	end

	assign avs_readdata     = rdata_ff;
	assign avs_waitrequest  = wait_ff;
	assign avs_response_err = err_ff;
	assign ee_req           = ee_req_ff;
	assign ee_loc           = ee_loc_ff;
	assign init_done        = done_ff;
	assign multicast_accept = accept_ff;
	assign station_address  = {addr_high_ff[15:0], addr_low_ff};
	assign mdc              = mdc_ff;
	assign mdio_out         = mdo_ff;
	assign mdio_oe_n        = oe_n_ff;
endmodule : mac_filt_regs

// ==== logic/mdc_divider.sv ====
// divider producing one-cycle enables at each management clock half period
// assumes a single system clock
`include "mac_filt_cfg.svh"
module mdc_divider #(
	parameter int half_cycles = `MDC_HALF_CYC
) (
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic run,
	output logic      tick
);
	initial if (half_cycles < 1) $error("half_cycles must be at least one");
	logic [15:0] cnt_ff;
	logic [15:0] nxt_cnt;
	logic        tick_ff;
	logic        nxt_tick;
	always_comb begin
		nxt_tick = 1'b0;
		nxt_cnt  = cnt_ff + 16'h0001;
		if (!run) begin
			nxt_cnt = 16'h0000;
		end else if (cnt_ff == 16'(half_cycles - 1)) begin
			nxt_cnt  = 16'h0000;
			nxt_tick = 1'b1;
		end
	end
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cnt_ff  <= 16'h0000;
			tick_ff <= 1'b0;
		end else begin
			cnt_ff  <= nxt_cnt;
			tick_ff <= nxt_tick;
		end
	end
	assign tick = tick_ff;
endmodule : mdc_divider

// ==== tb/far_side_model.sv ====
// model of the serial eeprom byte port and the internal phy management pins
// assumes one system clock; mdio has a pull-up when nobody drives it
module far_side_model #(
	parameter logic [47:0] ee_image = 48'hBC9A78563412,
	parameter logic [15:0] rd_value = 16'h5A3C
) (
	input wire logic        clock,
	input wire logic [3:0]  ee_lat,
	input wire logic        ee_req,
	input wire logic [7:0]  ee_loc,
	output logic            ee_ack,
	output logic [7:0]      ee_data,
	input wire logic        mdc,
	input wire logic        mdio_out,
	input wire logic        mdio_oe_n,
	output logic            mdio_in,
	output logic [63:0]     frame_bits
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] wait_ff = 4'h0;
	logic [4:0] rd_cnt = 5'h13;
	logic       mdc_q  = 1'b0;
	initial ee_ack = 1'b0;
	initial ee_data = 8'h00;
	// answer each location after ee_lat cycles; data toggles when not valid
	always @(posedge clock) begin
		ee_ack <= 1'b0;
		ee_data <= ~ee_data;
		wait_ff <= 4'h0;
		if (ee_req && !ee_ack && wait_ff >= ee_lat) begin
			ee_ack <= 1'b1;
			ee_data <= ee_image[8 * (ee_loc - 8'h01) +: 8];
		end else if (ee_req && !ee_ack) begin
			wait_ff <= wait_ff + 4'h1;
		end
	end
	always @(posedge mdc) begin
		if (!mdio_oe_n) frame_bits <= {frame_bits[62:0], mdio_out};
	end
	// count mdc falls after release, seen one clock late so oe_n has settled:
	// first turnaround bit floats high, second is zero, then data msb first
	always @(posedge clock) begin
		mdc_q <= mdc;
		if (mdc_q && !mdc) rd_cnt <= !mdio_oe_n ? 5'h00 : (rd_cnt < 5'h13 ? rd_cnt + 5'h01 : rd_cnt);
	end
	always_comb begin
		if (!mdio_oe_n) mdio_in = mdio_out;
		else if (rd_cnt == 5'h02) mdio_in = 1'b0;
		else if (rd_cnt >= 5'h03 && rd_cnt <= 5'h12) mdio_in = rd_value[5'h12 - rd_cnt];
		else mdio_in = 1'b1;
	end
endmodule : far_side_model

// ==== tb/mac_filt_regs_sva.sv ====
// port checker for the mac address, hash and phy management bank
// assumes it is bound onto mac_filt_regs and sees only its ports
module mac_filt_regs_sva #(
	parameter int mdc_half = 20
) (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic        avs_waitrequest,
	input wire logic        avs_response_err,
	input wire logic        ee_req,
	input wire logic        ee_ack,
	input wire logic [7:0]  ee_loc,
	input wire logic        init_done,
	input wire logic [47:0] station_address,
	input wire logic        mdc
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	logic       mdc_q_ff;
	logic [7:0] hold_ff;
	logic [7:0] nxt_hold;
	// cycles the management clock has held its level
	always_comb nxt_hold = (mdc != mdc_q_ff) ? 8'h00 : hold_ff + 8'h01;
	always_ff @(posedge clock) begin
		mdc_q_ff <= mdc;
		hold_ff <= nxt_hold;
	end
	wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	wait_answer_a: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
		else $error("access not answered after one wait state");
	err_map_a: assert property ((avs_read || avs_write) && !avs_waitrequest
		|-> avs_response_err == !(avs_address inside {[4'h2:4'h7], 4'h9})) else $error("wrong error response");
	addr_cause_a: assert property (!$stable(station_address) |-> $past(ee_ack)
		|| $past(avs_write && !avs_waitrequest && avs_address inside {4'h2, 4'h3}))
		else $error("station address changed without cause");
	ee_step_a: assert property (ee_req && ee_ack && ee_loc != 8'h06
		|=> ee_req && ee_loc == $past(ee_loc) + 8'h01) else $error("eeprom location did not advance");
	ee_first_a: assert property ($rose(ee_req) |-> ee_loc == 8'h01)
		else $error("eeprom load not started at location one");
	load_end_a: assert property (ee_req && ee_ack && ee_loc == 8'h06 |=> !ee_req && init_done)
		else $error("eeprom load did not finish at location six");
	init_hold_a: assert property (init_done |=> init_done && !ee_req)
		else $error("init done dropped or load restarted");
	mdc_half_a: assert property ($fell(mdc) |-> hold_ff == mdc_half - 1)
		else $error("management clock high phase wrong length");
	cover property (ee_req && ee_ack && ee_loc == 8'h06);
	cover property (avs_response_err && !avs_waitrequest);
	cover property ($fell(mdc));
endmodule : mac_filt_regs_sva

bind mac_filt_regs mac_filt_regs_sva #(.mdc_half(mdc_half)) u_sva (.*);

// ==== tb/testbench.sv ====
// self-checking bench for the mac address, hash and phy management bank
// assumes far_side_model answers the eeprom and mdio pins
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock, rst_n, avs_read, avs_write, avs_waitrequest, avs_response_err;
	logic        ee_present, ee_ack, ee_req, init_done, multicast_accept, mdc, mdio_out, mdio_oe_n, mdio_in;
	logic [3:0]  avs_address, avs_byteenable, ee_lat;
	logic [7:0]  ee_data, ee_loc;
	logic [5:0]  hash_index;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [47:0] station_address;
	logic [63:0] frame_bits, tbl;
	logic        q_err;
	int          miscompares, n_compared, i;
	logic [5:0]  idx_list [6] = '{6'h00, 6'h01, 6'h1F, 6'h20, 6'h21, 6'h3F};
	mac_filt_regs #(.mdc_half(2)) u_dut (.*);
	far_side_model u_far (.*);
	task automatic results;
		$display("compared %0d miscompared %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : results
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		n_compared++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			miscompares++;
		end
	endtask : chk
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge clock);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= d;
		for (n = 0; n < 20; n++) begin
			@(posedge clock);
			if (avs_waitrequest === 1'b0) break;
		end
		q = avs_readdata;
		q_err = avs_response_err;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n == 20) begin miscompares++; results(); end
	endtask : bus
	task automatic rd(input logic [3:0] a, input logic [31:0] e, input string w);
		bus(1'b0, a, 32'h0);
		chk(w, e, q);
	endtask : rd
	task automatic poll;
		int n;
		for (n = 0; n < 500; n++) begin
			bus(1'b0, 4'h6, 32'h0);
			if (q[0] === 1'b0) break;
		end
		if (n == 500) begin miscompares++; results(); end
	endtask : poll
	task automatic boot(input logic p, input logic [3:0] lat);
		int n;
		rst_n <= 1'b0;
		ee_present <= p;
		ee_lat <= lat;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge clock);
			if (init_done === 1'b1) break;
		end
		if (n == 200) begin miscompares++; results(); end
	endtask : boot
	task automatic hash(input logic [5:0] x, input logic e);
		hash_index <= x;
		repeat (2) @(posedge clock);
		chk("multicast_accept", e, multicast_accept);
	endtask : hash
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	initial begin
		{avs_read, avs_write, avs_address, avs_writedata, hash_index} = '0;
		avs_byteenable = 4'hF;
		boot(1'b1, 4'h3);
		chk("station_address", 48'hBC9A78563412, station_address);
		rd(4'h2, 32'h0000BC9A, "address_high");
		rd(4'h3, 32'h78563412, "address_low");
		boot(1'b0, 4'h0);
		rd(4'h2, 32'h00000FFF, "address_high");
		rd(4'h3, 32'h0FFFFFFF, "address_low");
		for (i = 4; i < 10; i++) if (i != 8) rd(i[3:0], 32'h0, "reset_value");
		bus(1'b1, 4'h2, 32'hFFFFFFFF);
		rd(4'h2, 32'h0000FFFF, "address_high");
		bus(1'b1, 4'h3, 32'h0BADF00D);
		@(posedge clock);
		chk("station_address", 48'hFFFF0BADF00D, station_address);
		rd(4'hF, 32'h0, "unmapped");
		chk("response_err", 1'b1, q_err);
		tbl = {32'h80000002, 32'h00000001};
		bus(1'b1, 4'h4, tbl[63:32]);
		bus(1'b1, 4'h5, tbl[31:0]);
		for (i = 0; i < 6; i++) hash(idx_list[i], tbl[idx_list[i]]);
		bus(1'b1, 4'h9, 32'h1);
		hash(6'h01, 1'b1);
		bus(1'b1, 4'h7, 32'h0000C3A5);
		bus(1'b1, 4'h6, {16'h0, 5'h01, 5'h0A, 6'h03});
		rd(4'h6, {16'h0, 5'h01, 5'h0A, 6'h03}, "busy_set");
		bus(1'b1, 4'h7, 32'h00001234);
		poll();
		rd(4'h7, 32'h0000C3A5, "write_data");
		rd(4'h6, {16'h0, 5'h01, 5'h0A, 6'h02}, "busy_clear");
		chk("write_frame", {32'hFFFFFFFF, 4'h5, 5'h01, 5'h0A, 2'b10, 16'hC3A5}, frame_bits);
		bus(1'b1, 4'h6, {16'h0, 5'h01, 5'h13, 6'h01});
		poll();
		rd(4'h7, 32'h00005A3C, "read_data");
		chk("read_frame", {50'h0, 4'h6, 5'h01, 5'h13}, frame_bits & 64'h3FFF);
		results();
	end
endmodule : testbench
